//--- sssfl_pkg.sv
// Package of constants and carriers for the lower second status flags
package sssfl_pkg;

  localparam int unsigned DATA_W                  = 32;
  localparam logic [7:0]  SECOND_STATUS_FLAGS_OFS = 8'h09;
  localparam logic [31:0] SECOND_STATUS_RESET     = 32'h00000000;

  localparam int unsigned BIT_STAMP_B        = 21;
  localparam int unsigned BIT_STAMP_A        = 20;
  localparam int unsigned BIT_PHY_EVENT      = 19;
  localparam int unsigned BIT_P2_URGENT      = 18;
  localparam int unsigned BIT_P2_WAITING     = 17;
  localparam int unsigned BIT_TX_ECC         = 12;
  localparam int unsigned BIT_RX_ECC         = 11;
  localparam int unsigned BIT_SPI_CRC        = 10;
  localparam int unsigned BIT_P1_SHORT_GAP   = 8;
  localparam int unsigned BIT_P1_URGENT      = 5;
  localparam int unsigned BIT_P1_WAITING     = 4;
  localparam int unsigned BIT_TX_READY       = 3;

  localparam int unsigned PORT_COUNT = 2;

  // Events from the surrounding device, one-cycle pulses
  typedef struct packed {
    logic stamp_slot_b_captured;
    logic stamp_slot_a_captured;
    logic tx_size_ecc_error;
    logic rx_size_ecc_error;
    logic spi_crc_error;
    logic port1_short_gap;
    logic frame_tx_done;
  } sssfl_events_s;

  // Per-port receive queue state
  typedef struct packed {
    logic hi_frame_queued;
    logic lo_frame_queued;
    logic threshold_reached;
    logic eof_received;
  } sssfl_rxq_s;

  // Register port access
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sssfl_reg_req_s;

endpackage : sssfl_pkg

//--- sssfl_rx_port.sv
// Per-port receive readiness and queue selection
module sssfl_rx_port (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire sssfl_pkg::sssfl_rxq_s rxq,
  input  wire logic               cut_through,
  input  wire logic               low_priority_first_select,
  output logic                    frame_waiting_q,
  output logic                    urgent_frame_waiting_q,
  output logic                    serve_high_q
);
  import sssfl_pkg::*;

  logic waiting_d;

  always_comb begin
    if (cut_through) begin
      waiting_d = rxq.threshold_reached | rxq.eof_received;
    end else begin
      waiting_d = rxq.hi_frame_queued | rxq.lo_frame_queued;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      frame_waiting_q        <= 1'b0;
      urgent_frame_waiting_q <= 1'b0;
    end else begin
      frame_waiting_q        <= waiting_d;
      urgent_frame_waiting_q <= rxq.hi_frame_queued;
    end
  end

  // High queue first unless low-first is selected
  always_ff @(posedge clock) begin
    if (reset) begin
      serve_high_q <= 1'b1;
    end else if (rxq.hi_frame_queued && rxq.lo_frame_queued) begin
      serve_high_q <= ~low_priority_first_select;
    end else begin
      serve_high_q <= rxq.hi_frame_queued;
    end
  end

endmodule : sssfl_rx_port

//--- sssfl_status.sv
// Lower 22 bits of the second status flags register
module sssfl_status (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire sssfl_pkg::sssfl_reg_req_s req,
  input  wire sssfl_pkg::sssfl_events_s  events,
  input  wire sssfl_pkg::sssfl_rxq_s     port1_rxq,
  input  wire sssfl_pkg::sssfl_rxq_s     port2_rxq,
  input  wire logic                     port2_phy_irq,
  input  wire logic                     generic_spi_mode,
  input  wire logic                     cut_through,
  input  wire logic                     low_priority_first_select,
  input  wire logic                     ready_on_empty,
  input  wire logic                     tx_fifo_empty,
  input  wire logic [15:0]              port1_gap_measured,
  input  wire logic [15:0]              port1_min_gap_setting,
  input  wire logic                     port1_frame_start,
  output logic [31:0]                   rdata_q,
  output logic                          rvalid_q,
  output logic                          tx_fifo_flush_q,
  output logic                          rx_fifo_flush_q,
  output logic                          port1_frame_drop_q,
  output logic                          port1_serve_high_q,
  output logic                          port2_serve_high_q
);
  import sssfl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic hit_write;
  logic hit_read;
  logic [31:0] clear_mask;

  always_comb begin
    hit_write = 1'b0;
    hit_read  = 1'b0;
    if (req.addr == SECOND_STATUS_FLAGS_OFS) begin
      hit_write = req.write;
      hit_read  = req.read;
    end
  end

  assign clear_mask = hit_write ? req.wdata : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags, set wins over clear

  logic stamp_b_q;
  logic stamp_a_q;
  logic tx_ecc_q;
  logic rx_ecc_q;
  logic spi_crc_q;
  logic short_gap_q;
  logic tx_ready_q;
  logic short_gap_event;
  logic tx_ready_event;

  assign short_gap_event = port1_frame_start && (port1_gap_measured < port1_min_gap_setting);
  assign tx_ready_event  = events.frame_tx_done && (!ready_on_empty || tx_fifo_empty);

  always_ff @(posedge clock) begin
    if (reset) begin
      stamp_b_q <= 1'b0;
      stamp_a_q <= 1'b0;
    end else begin
      stamp_b_q <= events.stamp_slot_b_captured | (stamp_b_q & ~clear_mask[BIT_STAMP_B]);
      stamp_a_q <= events.stamp_slot_a_captured | (stamp_a_q & ~clear_mask[BIT_STAMP_A]);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_ecc_q <= 1'b0;
      rx_ecc_q <= 1'b0;
    end else begin
      tx_ecc_q <= events.tx_size_ecc_error | (tx_ecc_q & ~clear_mask[BIT_TX_ECC]);
      rx_ecc_q <= events.rx_size_ecc_error | (rx_ecc_q & ~clear_mask[BIT_RX_ECC]);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      spi_crc_q <= 1'b0;
    end else begin
      spi_crc_q <= (events.spi_crc_error & generic_spi_mode) | (spi_crc_q & ~clear_mask[BIT_SPI_CRC]);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      short_gap_q <= 1'b0;
    end else begin
      short_gap_q <= short_gap_event | (short_gap_q & ~clear_mask[BIT_P1_SHORT_GAP]);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_ready_q <= 1'b0;
    end else begin
      tx_ready_q <= tx_ready_event | (tx_ready_q & ~clear_mask[BIT_TX_READY]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // FIFO flush and frame drop pulses

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_fifo_flush_q    <= 1'b0;
      rx_fifo_flush_q    <= 1'b0;
      port1_frame_drop_q <= 1'b0;
    end else begin
      tx_fifo_flush_q    <= events.tx_size_ecc_error;
      rx_fifo_flush_q    <= events.rx_size_ecc_error;
      port1_frame_drop_q <= short_gap_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-only live flags

  logic phy_event_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      phy_event_q <= 1'b0;
    end else begin
      phy_event_q <= port2_phy_irq;
    end
  end

  logic p1_waiting;
  logic p1_urgent;
  logic p2_waiting;
  logic p2_urgent;

  sssfl_rx_port u_port1 (
    .clock                     (clock),
    .reset                     (reset),
    .rxq                       (port1_rxq),
    .cut_through               (cut_through),
    .low_priority_first_select (low_priority_first_select),
    .frame_waiting_q           (p1_waiting),
    .urgent_frame_waiting_q    (p1_urgent),
    .serve_high_q              (port1_serve_high_q)
  );

  sssfl_rx_port u_port2 (
    .clock                     (clock),
    .reset                     (reset),
    .rxq                       (port2_rxq),
    .cut_through               (cut_through),
    .low_priority_first_select (low_priority_first_select),
    .frame_waiting_q           (p2_waiting),
    .urgent_frame_waiting_q    (p2_urgent),
    .serve_high_q              (port2_serve_high_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data assembly

  logic [31:0] image;

  always_comb begin
    image                   = SECOND_STATUS_RESET;
    image[BIT_STAMP_B]      = stamp_b_q;
    image[BIT_STAMP_A]      = stamp_a_q;
    image[BIT_PHY_EVENT]    = phy_event_q;
    image[BIT_P2_URGENT]    = p2_urgent & generic_spi_mode;
    image[BIT_P2_WAITING]   = p2_waiting & generic_spi_mode;
    image[BIT_TX_ECC]       = tx_ecc_q;
    image[BIT_RX_ECC]       = rx_ecc_q;
    image[BIT_SPI_CRC]      = spi_crc_q;
    image[BIT_P1_SHORT_GAP] = short_gap_q;
    image[BIT_P1_URGENT]    = p1_urgent & generic_spi_mode;
    image[BIT_P1_WAITING]   = p1_waiting & generic_spi_mode;
    image[BIT_TX_READY]     = tx_ready_q & generic_spi_mode;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.read;
      if (hit_read) begin
        rdata_q <= image;
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

endmodule : sssfl_status

//--- sssfl_status_checker.sv
// Port assertions for the lower second status flags
module sssfl_status_chk (
  input wire logic                     clock,
  input wire logic                     reset,
  input wire sssfl_pkg::sssfl_reg_req_s req,
  input wire sssfl_pkg::sssfl_events_s  events,
  input wire logic                     port2_phy_irq,
  input wire logic                     generic_spi_mode,
  input wire logic [15:0]              port1_gap_measured,
  input wire logic [15:0]              port1_min_gap_setting,
  input wire logic                     port1_frame_start,
  input wire logic [31:0]              rdata_q,
  input wire logic                     rvalid_q,
  input wire logic                     tx_fifo_flush_q,
  input wire logic                     rx_fifo_flush_q,
  input wire logic                     port1_frame_drop_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import sssfl_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_reserved_read_zero: assert property (rvalid_q |-> (rdata_q & 32'h0001E2C7) == 32'h0)
    else $error("reserved bits set");
  chk_bad_addr_zero: assert property (req.read && req.addr != SECOND_STATUS_FLAGS_OFS
    |=> rvalid_q && rdata_q == 32'h0) else $error("unmapped read not zero");
  chk_tx_ecc_flush: assert property (events.tx_size_ecc_error |-> ##[1:2] tx_fifo_flush_q)
    else $error("tx fifo not flushed");
  chk_rx_ecc_flush: assert property (events.rx_size_ecc_error |-> ##[1:2] rx_fifo_flush_q)
    else $error("rx fifo not flushed");
  chk_short_gap_drop: assert property (port1_frame_start && port1_gap_measured < port1_min_gap_setting
    |=> port1_frame_drop_q) else $error("short gap frame kept");
  chk_phy_event_mirror: assert property (req.read && req.addr == SECOND_STATUS_FLAGS_OFS
    |=> rdata_q[BIT_PHY_EVENT] == $past(port2_phy_irq, 2)) else $error("phy flag wrong");
  chk_stamp_b_seen: assert property (events.stamp_slot_b_captured
    ##[1:3] (req.read && req.addr == SECOND_STATUS_FLAGS_OFS) |=> rdata_q[21]) else $error("stamp flag missing");
  chk_mode_gate_zero: assert property (!generic_spi_mode
    ##1 (req.read && req.addr == SECOND_STATUS_FLAGS_OFS && !generic_spi_mode)
    |=> rdata_q[18:17] == 2'h0 && rdata_q[5:3] == 3'h0 && !rdata_q[10]) else $error("gated bits set");
  cov_tx_done: cover property (events.frame_tx_done);
  cov_gap_drop: cover property (port1_frame_drop_q);
  cov_write: cover property (req.write);
  cov_set_and_clear: cover property (events.stamp_slot_b_captured && req.write && req.wdata[21]);
endmodule : sssfl_status_chk
bind sssfl_status sssfl_status_chk u_chk (
  .clock                 (clock),
  .reset                 (reset),
  .req                   (req),
  .events                (events),
  .port2_phy_irq         (port2_phy_irq),
  .generic_spi_mode      (generic_spi_mode),
  .port1_gap_measured    (port1_gap_measured),
  .port1_min_gap_setting (port1_min_gap_setting),
  .port1_frame_start     (port1_frame_start),
  .rdata_q               (rdata_q),
  .rvalid_q              (rvalid_q),
  .tx_fifo_flush_q       (tx_fifo_flush_q),
  .rx_fifo_flush_q       (rx_fifo_flush_q),
  .port1_frame_drop_q    (port1_frame_drop_q)
);

//--- sssfl_host.sv
// Host model issuing register reads and writes
module sssfl_host (
  input  wire logic                 clock,
  input  wire logic [31:0]          rdata_q,
  input  wire logic                 rvalid_q,
  output sssfl_pkg::sssfl_reg_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  import sssfl_pkg::*;
  initial req = '0;
  // Single read or write; read data sampled one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(negedge clock);
    req <= '{write: w, read: !w, addr: a, wdata: d};
    @(negedge clock);
    req <= '0;
    q = rvalid_q ? rdata_q : 32'hXXXXXXXX;
  endtask : acc
endmodule : sssfl_host

//--- sssfl_status_tb.sv
// Self-checking bench for the lower second status flags
module sssfl_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sssfl_pkg::*;
  logic clock = 0, reset = 1, gen = 1, cut = 0, lpf = 0, roe = 0, empty = 1, irq = 0, start = 0;
  logic [6:0] ev = '0;
  logic [15:0] gap = '0, mgap = 16'h0010;
  sssfl_rxq_s q1 = '0, q2 = '0;
  sssfl_reg_req_s req;
  logic [31:0] rdata, got;
  logic rvalid, sh1, sh2;
  int mismatches = 0, compares = 0;
  always #12.5 clock = ~clock;
  sssfl_status dut (.clock(clock), .reset(reset), .req(req), .events(ev), .port1_rxq(q1), .port2_rxq(q2),
    .port2_phy_irq(irq), .generic_spi_mode(gen), .cut_through(cut), .low_priority_first_select(lpf),
    .ready_on_empty(roe), .tx_fifo_empty(empty), .port1_gap_measured(gap), .port1_min_gap_setting(mgap),
    .port1_frame_start(start), .rdata_q(rdata), .rvalid_q(rvalid), .tx_fifo_flush_q(), .rx_fifo_flush_q(),
    .port1_frame_drop_q(), .port1_serve_high_q(sh1), .port2_serve_high_q(sh2));
  sssfl_host host (.clock(clock), .rdata_q(rdata), .rvalid_q(rvalid), .req(req));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [31:0] e);
    host.acc(1'b0, SECOND_STATUS_FLAGS_OFS, '0, got);
    chk(got, e);
  endtask : rd
  task automatic wr(input logic [31:0] d);
    logic [31:0] x;
    host.acc(1'b1, SECOND_STATUS_FLAGS_OFS, d, x);
  endtask : wr
  task automatic pulse(input int i);
    @(negedge clock) ev <= 7'h01 << i;
    @(negedge clock) ev <= '0;
  endtask : pulse
  function automatic logic [31:0] rxf(sssfl_rxq_s a, sssfl_rxq_s b, logic c);
    logic [31:0] r;
    r = '0;
    r[4] = c ? a.threshold_reached | a.eof_received : a.hi_frame_queued | a.lo_frame_queued;
    r[5] = a.hi_frame_queued;
    r[17] = c ? b.threshold_reached | b.eof_received : b.hi_frame_queued | b.lo_frame_queued;
    r[18] = b.hi_frame_queued;
    return r;
  endfunction : rxf
  // Expected queue choice: high first unless low-first, else follow high
  function automatic logic srv(sssfl_rxq_s a, logic l);
    return (a.hi_frame_queued && a.lo_frame_queued) ? !l : a.hi_frame_queued;
  endfunction : srv
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    int evb[6] = '{6, 5, 4, 3, 2, 0};
    int rgb[6] = '{21, 20, 12, 11, 10, 3};
    void'($urandom(43));
    repeat (3) @(negedge clock);
    reset = 0;
    rd(32'h0);
    for (int k = 0; k < 6; k++) begin
      pulse(evb[k]);
      rd(32'h1 << rgb[k]);
      wr($urandom & ~(32'h1 << rgb[k]));
      rd(32'h1 << rgb[k]);
      wr(32'h1 << rgb[k]);
      rd(32'h0);
    end
    // Event and clear in one cycle: set wins
    fork
      pulse(6);
      wr(32'h1 << BIT_STAMP_B);
    join
    rd(32'h1 << BIT_STAMP_B);
    // Reset in mid-run wipes every flag
    pulse(5);
    reset = 1;
    repeat (3) @(negedge clock);
    reset = 0;
    chk({31'h0, sh1}, 32'h1);
    rd(32'h0);
    roe = 1;
    empty = 0;
    pulse(0);
    rd(32'h0);
    empty = 1;
    pulse(0);
    rd(32'h8);
    wr(32'h8);
    for (int k = 0; k < 2; k++) begin
      gap = (k == 0) ? mgap - 16'h0001 : mgap;
      start = 1;
      @(negedge clock) start = 0;
      rd(k == 0 ? 32'h100 : 32'h0);
      wr(32'h100);
    end
    repeat (16) begin
      q1 = 4'($urandom);
      q2 = 4'($urandom);
      cut = 1'($urandom);
      lpf = 1'($urandom);
      irq = 1'($urandom);
      @(negedge clock);
      rd(rxf(q1, q2, cut) | {12'h0, irq, 19'h0});
      chk({31'h0, sh1}, {31'h0, srv(q1, lpf)});
      chk({31'h0, sh2}, {31'h0, srv(q2, lpf)});
    end
    host.acc(1'b0, 8'h0A, '0, got);
    chk(got, 32'h0);
    gen = 0;
    q1 = 4'hF;
    q2 = 4'hF;
    irq = 0;
    pulse(2);
    pulse(0);
    rd(32'h0);
    test_done;
  end
endmodule : sssfl_status_tb
